// *** icc_pkg.sv ***
// Purpose: shared constants, types and helpers of the instruction cache
// Assumes: 10 MHz pclk, one APB control register
// Notes:   Contract
// Contract
// R1 - prom and ram areas cacheable, rest not
// R2 - 32 KB, four 8 KB ways, 32-byte lines
// R3 - tag holds address tag plus per-word valid
// R4 - fill empty ways first, then replace lru
// R5 - disabled: no lookup, fetch goes to memory
// R6 - enabled: hits served, misses fetched and stored
// R7 - frozen: like enabled but never allocate
// R8 - freeze-on-irq freezes when interrupt taken
// R9 - only software write re-enables after freeze
// R10 - two parity bits per tag and word
// R11 - tag parity error: miss, clear other valid bits
// R12 - data parity error: miss, rewrite that word only (with burst on, the code refills from that word to the line end)
// R13 - error counters saturate at three until cleared
// R14 - no burst: miss loads exactly one word
// R15 - burst: fill to line end, streaming words
// R16 - integer unit stalls: hold until fill ends
// R17 - control transfer aborts fill at next fetch
// R18 - burst streams even while cache disabled
// R19 - flush by instruction or bit; pending flag
// R20 - flush one cycle per line per way
// R21 - memory error leaves word valid bit clear
// R22 - failing fetch signals trap type 0x01
// R23 - pending flag drops with last invalidation

package icc_pkg;
    // ------------------------------------------------------------
    // geometry
    // ------------------------------------------------------------
    localparam int WAYS = 4; // R2
    localparam int SETS = 256;
    localparam int IDX_W = 8;
    localparam int TAG_W = 19;
    localparam int TAG_E_W = 29;
    localparam int DAT_E_W = 34;
    localparam logic [9:0] FLUSH_LAST = 10'h3ff;
    localparam logic [7:0] LRU_INIT = 8'he4;
    // ------------------------------------------------------------
    // address map
    // ------------------------------------------------------------
    localparam logic [31:0] PROM_HI = 32'h1fffffff;
    localparam logic [31:0] RAM_LO = 32'h40000000;
    localparam logic [31:0] RAM_HI = 32'h7fffffff;
    localparam logic [11:0] REG_CTRL = 12'h000;
    // ------------------------------------------------------------
    // control register fields
    // ------------------------------------------------------------
    localparam int FLD_MODE = 0;
    localparam int FLD_FRZ = 2;
    localparam int FLD_FLUSH = 3;
    localparam int FLD_PEND = 4;
    localparam int FLD_BURST = 5;
    localparam int FLD_TERR = 6;
    localparam int FLD_DERR = 8;
    localparam logic [1:0] ERR_MAX = 2'h3;
    localparam logic [7:0] TRAP_FETCH = 8'h01;

    typedef enum logic [1:0] {
        MODE_DIS = 2'h0,
        MODE_FRZ = 2'h1,
        MODE_ENA = 2'h3
    } icc_mode_type;

    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_LOOK = 2'h1,
        ST_FILL = 2'h3
    } icc_state_type;

    typedef struct packed {
        logic [31:0] data;
        logic [31:0] addr;
        logic err;
        logic [7:0] trap_type;
    } icc_fetch_type;

    typedef struct packed {
        logic req;
        logic [31:0] addr;
        logic burst;
    } icc_mem_req_type;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [1:0] par2(input logic [63:0] v);
        return {^(v & 64'haaaaaaaaaaaaaaaa), ^(v & 64'h5555555555555555)};
    endfunction

    function automatic logic [1:0] tag_par(input logic [18:0] t,
        input logic [7:0] vld, input logic [7:0] idx);
        return par2({29'h0, t, vld, idx});
    endfunction

    function automatic logic [1:0] dat_par(input logic [31:0] d,
        input logic [7:0] idx, input logic [2:0] wd);
        return par2({21'h0, d, idx, wd});
    endfunction

    function automatic logic cacheable(input logic [31:0] a);
        return a <= PROM_HI || (a >= RAM_LO && a <= RAM_HI);
    endfunction

    // age list: most recent way in the top bits, oldest in the bottom
    function automatic logic [1:0] lru_victim(input logic [7:0] v);
        return v[1:0];
    endfunction

    function automatic logic [7:0] lru_touch(input logic [7:0] v,
        input logic [1:0] w);
        logic [7:0] r;
        logic [1:0] p;
        r = {w, 6'h00};
        p = 2'h2;
        for (int i = 3; i >= 0; i--) begin
            if (v[2*i+:2] != w) begin
                r[2*p+:2] = v[2*i+:2];
                p = p - 2'h1;
            end
        end
        return r;
    endfunction
endpackage

// *** icc_ram.sv ***
// Purpose: one-port-write ram with registered read data
// Assumes: contents undefined until written
// Notes:   used for tag and data arrays of each way
`timescale 1ns/100ps
`default_nettype none
module icc_ram #(
    parameter int W = 32,
    parameter int AW = 8
) (
    // clock
    input wire logic pclk,
    // write side
    input wire logic we,
    input wire logic [AW-1:0] waddr,
    input wire logic [W-1:0] wdata,
    // read side
    input wire logic [AW-1:0] raddr,
    output logic [W-1:0] rdata
);
    logic [W-1:0] mem [2**AW];

    always_ff @(posedge pclk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    always_ff @(posedge pclk) begin
        rdata <= mem[raddr];
    end
endmodule
`default_nettype wire

// *** icc_satcnt.sv ***
// Purpose: saturating error counter
// Assumes: clear and increment may coincide
// Notes:   clear with increment together leaves a count of one
`timescale 1ns/100ps
`default_nettype none
module icc_satcnt
    import icc_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // control
    input wire logic inc,
    input wire logic clr,
    output logic [1:0] cnt
);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt <= 2'h0;
        end else if (clr) begin
            cnt <= inc ? 2'h1 : 2'h0;
        end else if (inc && cnt != ERR_MAX) begin
            cnt <= cnt + 2'h1; // R13
        end
    end

    AST_CNT_SAT: assert property (@(posedge pclk) disable iff (!presetn)
        cnt == ERR_MAX && !clr |=> cnt == ERR_MAX) // R13
        else $error("error counter left saturation");
endmodule
`default_nettype wire

// *** icc_top.sv ***
// Purpose: 4-way instruction cache controller with apb control
// Assumes: fetch_req held until fetch_valid; memory acks each word
// Notes:   flush runs automatically after reset
//
// The address map and register access over APB were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module icc_top (
    // apb
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // integer unit
    input wire logic fetch_req,
    input wire logic [31:0] fetch_addr,
    input wire logic iu_ready,
    input wire logic iu_cti,
    input wire logic irq_taken,
    input wire logic flush_insn,
    output logic fetch_valid,
    output icc_pkg::icc_fetch_type fetch_rsp,
    output logic iu_hold,
    // memory controller
    output icc_pkg::icc_mem_req_type mem_out,
    input wire logic mem_ack,
    input wire logic [31:0] mem_rdata,
    input wire logic mem_err
);
    import icc_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    icc_mode_type mode;
    icc_state_type state;
    logic frz_en, burst_en, flush_pend, wr_ev, flush_start;
    logic [9:0] flush_ctr;
    logic [1:0] terr_cnt, derr_cnt;
    logic [31:0] req_addr;
    logic [2:0] fill_word;
    logic [1:0] fill_way;
    logic [7:0] fill_valid, new_valid;
    logic fill_wr, fill_keep, first_done, abort_pend, fill_last;
    logic [7:0] lru [SETS];
    logic [TAG_E_W-1:0] tag_q [WAYS];
    logic [DAT_E_W-1:0] dat_q [WAYS];
    logic [WAYS-1:0] tag_we, dat_we;
    logic [IDX_W-1:0] tag_wa, rd_idx;
    logic [TAG_E_W-1:0] tag_wd;
    logic [DAT_E_W-1:0] dat_wd;
    logic [2:0] rd_word;
    logic hit_any, keep_any, terr_any, empty_any, derr_any, fill_ok, look_ok;
    logic [1:0] hit_way, keep_way, terr_way, empty_way, victim;
    logic [31:0] word_addr, rd_val;
    wire logic [7:0] idx = req_addr[12:5];
    wire logic [2:0] wrd = req_addr[4:2];

    // ------------------------------------------------------------
    // tag and data arrays
    // ------------------------------------------------------------
    assign rd_idx = (state == ST_IDLE) ? fetch_addr[12:5] : idx;
    assign rd_word = (state == ST_IDLE) ? fetch_addr[4:2] : wrd;

    for (genvar w = 0; w < WAYS; w++) begin : g_way
        icc_ram #(.W(TAG_E_W), .AW(IDX_W)) u_tag (
            .pclk(pclk),
            .we(tag_we[w]),
            .waddr(tag_wa),
            .wdata(tag_wd),
            .raddr(rd_idx),
            .rdata(tag_q[w])
        );
        icc_ram #(.W(DAT_E_W), .AW(IDX_W + 3)) u_dat (
            .pclk(pclk),
            .we(dat_we[w]),
            .waddr({idx, fill_word}),
            .wdata(dat_wd),
            .raddr({rd_idx, rd_word}),
            .rdata(dat_q[w])
        );
    end

    icc_satcnt u_terr (
        .pclk(pclk),
        .presetn(presetn),
        .inc(state == ST_LOOK && !hit_any && terr_any),
        .clr(wr_ev && pwdata[FLD_TERR+:2] == 2'h0),
        .cnt(terr_cnt)
    );

    icc_satcnt u_derr (
        .pclk(pclk),
        .presetn(presetn),
        .inc(state == ST_LOOK && !hit_any && derr_any),
        .clr(wr_ev && pwdata[FLD_DERR+:2] == 2'h0),
        .cnt(derr_cnt)
    );

    // ------------------------------------------------------------
    // lookup
    // ------------------------------------------------------------
    always_comb begin
        logic [TAG_E_W-1:0] t;
        logic ok, m, dok;
        t = '0;
        ok = 1'b0;
        m = 1'b0;
        dok = 1'b0;
        hit_any = 1'b0;
        keep_any = 1'b0;
        terr_any = 1'b0;
        empty_any = 1'b0;
        derr_any = 1'b0;
        hit_way = 2'h0;
        keep_way = 2'h0;
        terr_way = 2'h0;
        empty_way = 2'h0;
        for (int w = WAYS - 1; w >= 0; w--) begin
            t = tag_q[w];
            ok = tag_par(t[26:8], t[7:0], idx) == t[28:27]; // R10
            m = ok && t[26:8] == req_addr[31:13]; // R3
            dok = dat_par(dat_q[w][31:0], idx, wrd) == dat_q[w][33:32];
            if (m && t[wrd] && dok) begin
                hit_any = 1'b1;
                hit_way = 2'(w);
            end
            if (m) begin
                keep_any = 1'b1;
                keep_way = 2'(w);
            end
            if (m && t[wrd] && !dok) begin
                derr_any = 1'b1; // R12
            end
            if (!ok) begin
                terr_any = 1'b1; // R11
                terr_way = 2'(w);
            end
            if (ok && t[7:0] == 8'h00) begin
                empty_any = 1'b1;
                empty_way = 2'(w);
            end
        end
    end

    always_comb begin
        victim = lru_victim(lru[idx]); // R4
        if (keep_any) begin
            victim = keep_way;
        end else if (terr_any) begin
            victim = terr_way;
        end else if (empty_any) begin
            victim = empty_way; // R4
        end
    end

    // frozen cache never takes a new line
    assign fill_ok = keep_any ? mode != MODE_DIS : mode == MODE_ENA; // R7
    assign look_ok = !flush_pend && (mode == MODE_ENA || mode == MODE_FRZ)
        && cacheable(fetch_addr); // R1 R5 R20

    // ------------------------------------------------------------
    // array writes
    // ------------------------------------------------------------
    assign word_addr = {req_addr[31:5], fill_word, 2'h0};
    assign new_valid = fill_valid | (8'h01 << fill_word);
    assign fill_last = !mem_out.burst || fill_word == 3'h7;

    always_comb begin
        tag_we = '0;
        dat_we = '0;
        tag_wa = idx;
        tag_wd = {tag_par(req_addr[31:13], new_valid, idx),
            req_addr[31:13], new_valid};
        dat_wd = {dat_par(mem_rdata, idx, fill_word), mem_rdata};
        if (flush_pend) begin
            tag_we[flush_ctr[9:8]] = 1'b1; // R20
            tag_wa = flush_ctr[7:0];
            tag_wd = {tag_par(19'h0, 8'h00, flush_ctr[7:0]), 27'h0};
        end else if (state == ST_FILL && mem_ack && fill_wr && !mem_err) begin
            tag_we[fill_way] = 1'b1; // R6 R21
            dat_we[fill_way] = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // fetch sequencer
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= ST_IDLE;
            req_addr <= '0;
            fill_word <= 3'h0;
            fill_way <= 2'h0;
            fill_valid <= 8'h00;
            fill_wr <= 1'b0;
            fill_keep <= 1'b0;
            first_done <= 1'b0;
            abort_pend <= 1'b0;
            iu_hold <= 1'b0;
            fetch_valid <= 1'b0;
            fetch_rsp <= '0;
            mem_out <= '0;
        end else begin
            fetch_valid <= 1'b0;
            unique case (state)
                ST_IDLE: begin
                    if (fetch_req && !fetch_valid) begin
                        req_addr <= fetch_addr;
                        fill_word <= fetch_addr[4:2];
                        fill_valid <= 8'h00;
                        fill_wr <= 1'b0;
                        fill_keep <= 1'b0;
                        first_done <= 1'b0;
                        abort_pend <= 1'b0;
                        if (look_ok) begin
                            state <= ST_LOOK;
                        end else begin
                            state <= ST_FILL; // R5 R18
                            mem_out <= '{1'b1, {fetch_addr[31:2], 2'h0},
                                burst_en && cacheable(fetch_addr)};
                        end
                    end
                end
                ST_LOOK: begin
                    if (hit_any) begin
                        fetch_valid <= 1'b1; // R6
                        fetch_rsp <= '{dat_q[hit_way][31:0], req_addr,
                            1'b0, 8'h00};
                        state <= ST_IDLE;
                    end else begin
                        state <= ST_FILL;
                        fill_way <= victim;
                        fill_keep <= keep_any;
                        fill_wr <= fill_ok;
                        // tag error refill keeps only the new word
                        fill_valid <= keep_any ? tag_q[keep_way][7:0] : 8'h00;
                        mem_out <= '{1'b1, {req_addr[31:2], 2'h0},
                            burst_en}; // R14 R15
                    end
                end
                ST_FILL: begin
                    if (iu_cti) begin
                        abort_pend <= 1'b1;
                    end
                    if (mem_ack) begin
                        fill_word <= fill_word + 3'h1;
                        if (!mem_err) begin
                            fill_valid <= new_valid;
                        end
                        if (!first_done) begin
                            first_done <= 1'b1;
                            fetch_valid <= 1'b1;
                            fetch_rsp <= '{mem_rdata, word_addr, mem_err,
                                mem_err ? TRAP_FETCH : 8'h00}; // R22
                        end else if (!abort_pend && !iu_hold && iu_ready
                            && !mem_err) begin
                            fetch_valid <= 1'b1; // R15
                            fetch_rsp <= '{mem_rdata, word_addr, 1'b0, 8'h00};
                        end else if (!abort_pend && !iu_ready) begin
                            iu_hold <= 1'b1; // R16
                        end
                        if (fill_last || (first_done && abort_pend)) begin
                            mem_out.req <= 1'b0; // R17
                            iu_hold <= 1'b0;
                            state <= ST_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // replacement ages
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < SETS; i++) begin
                lru[i] <= LRU_INIT;
            end
        end else if (state == ST_LOOK && hit_any) begin
            lru[idx] <= lru_touch(lru[idx], hit_way);
        end else if (state == ST_LOOK && fill_ok) begin
            lru[idx] <= lru_touch(lru[idx], victim); // R4
        end
    end

    // ------------------------------------------------------------
    // flush
    // ------------------------------------------------------------
    assign flush_start = flush_insn || (wr_ev && pwdata[FLD_FLUSH]); // R19

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flush_pend <= 1'b1;
            flush_ctr <= 10'h000;
        end else if (flush_start) begin
            flush_pend <= 1'b1; // R19
            flush_ctr <= 10'h000;
        end else if (flush_pend) begin
            flush_ctr <= flush_ctr + 10'h001; // R20
            if (flush_ctr == FLUSH_LAST) begin
                flush_pend <= 1'b0; // R23
            end
        end
    end

    // ------------------------------------------------------------
    // control register and apb
    // ------------------------------------------------------------
    assign wr_ev = psel && penable && pready && pwrite && paddr == REG_CTRL;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode <= MODE_DIS;
        end else if (irq_taken && frz_en && mode == MODE_ENA) begin
            mode <= MODE_FRZ; // R8 R9
        end else if (wr_ev) begin
            unique case (pwdata[FLD_MODE+:2])
                2'h1: mode <= MODE_FRZ;
                2'h3: mode <= MODE_ENA;
                default: mode <= MODE_DIS;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            frz_en <= 1'b0;
            burst_en <= 1'b0;
        end else if (wr_ev) begin
            frz_en <= pwdata[FLD_FRZ];
            burst_en <= pwdata[FLD_BURST];
        end
    end

    always_comb begin
        rd_val = 32'h0;
        rd_val[FLD_MODE+:2] = mode;
        rd_val[FLD_FRZ] = frz_en;
        rd_val[FLD_PEND] = flush_pend; // R19
        rd_val[FLD_BURST] = burst_en;
        rd_val[FLD_TERR+:2] = terr_cnt;
        rd_val[FLD_DERR+:2] = derr_cnt;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0;
        end else begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && paddr != REG_CTRL;
            if (psel && !penable) begin
                prdata <= (paddr == REG_CTRL) ? rd_val : 32'h0;
            end
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence s_look_miss;
        state == ST_LOOK && !hit_any;
    endsequence

    sequence s_fill_start;
        state == ST_FILL && mem_out.req;
    endsequence

    AST_MISS_FILL: assert property (s_look_miss |=> s_fill_start) // R6
        else $error("miss did not start a fill");
    AST_DIS_BYPASS: assert property (state == ST_IDLE && fetch_req
        && !fetch_valid && mode == MODE_DIS |=> s_fill_start) // R5
        else $error("disabled fetch did not bypass");
    AST_UNCACHED: assert property (state == ST_IDLE && fetch_req
        && !fetch_valid && !cacheable(fetch_addr) |=> state == ST_FILL) // R1
        else $error("uncacheable fetch looked up");
    AST_NO_ALLOC: assert property (state == ST_LOOK && !hit_any
        && mode == MODE_FRZ && !keep_any |=> !fill_wr) // R7
        else $error("frozen cache allocated");
    AST_FREEZE: assert property (irq_taken && frz_en && mode == MODE_ENA
        |=> mode == MODE_FRZ) // R8
        else $error("interrupt did not freeze");
    AST_STAY_FROZEN: assert property (mode == MODE_FRZ && !wr_ev
        |=> mode == MODE_FRZ) // R9
        else $error("left frozen without software");
    AST_FLUSH_STEP: assert property (flush_pend && flush_ctr != FLUSH_LAST
        && !flush_start |=> flush_pend
        && flush_ctr == $past(flush_ctr) + 10'h001) // R20
        else $error("flush did not advance");
    AST_FLUSH_END: assert property (flush_pend && flush_ctr == FLUSH_LAST
        && !flush_start |=> !flush_pend) // R23
        else $error("pending flag stuck");
    AST_SINGLE: assert property (mem_out.req && !mem_out.burst && mem_ack
        |=> !mem_out.req) // R14
        else $error("single fetch loaded more");
    AST_HOLD: assert property (iu_hold |=> !fetch_valid) // R16
        else $error("streamed while held");
    AST_TRAP: assert property (fetch_valid && fetch_rsp.err
        |-> fetch_rsp.trap_type == TRAP_FETCH) // R22
        else $error("wrong fetch trap type");
endmodule
`default_nettype wire

// *** icc_mem_model.sv ***
// Purpose: memory controller model for the instruction cache
// Assumes: word data is the inverse of its address
// Notes: err_inj marks every acked word as failing
`timescale 1ns/100ps
`default_nettype none
module icc_mem_model (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // memory side
    input wire icc_pkg::icc_mem_req_type mem_out,
    input wire logic err_inj,
    output logic mem_ack,
    output logic [31:0] mem_rdata,
    output logic mem_err,
    output logic [7:0] n_req
);
    import icc_pkg::*;
    logic busy;
    logic [31:0] a;
    logic [3:0] left;
    logic [1:0] dly;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy <= 1'b0;
            mem_ack <= 1'b0;
            mem_err <= 1'b0;
            mem_rdata <= 32'h0;
            n_req <= 8'h0;
            a <= 32'h0;
            left <= 4'h0;
            dly <= 2'h0;
        end else begin
            mem_ack <= 1'b0;
            mem_err <= 1'b0;
            mem_rdata <= ~mem_rdata;
            if (!busy && mem_out.req && !mem_ack) begin
                busy <= 1'b1;
                a <= mem_out.addr;
                // words from the missed one to the line end
                left <= mem_out.burst ? 4'h8 - {1'b0, mem_out.addr[4:2]}
                    : 4'h1;
                n_req <= n_req + 8'h1;
                dly <= 2'h2;
            end else if (busy && !mem_out.req) begin
                busy <= 1'b0;
            end else if (busy && dly != 2'h0) begin
                dly <= dly - 2'h1;
            end else if (busy) begin
                mem_ack <= 1'b1;
                mem_rdata <= ~a;
                mem_err <= err_inj;
                a <= a + 32'h4;
                left <= left - 4'h1;
                dly <= 2'h1;
                busy <= left != 4'h1;
            end
        end
    end
endmodule
`default_nettype wire

// *** tb.sv ***
// Purpose: self-checking bench of the instruction cache
// Assumes: zero-wait apb, flush after reset
// Notes: memory word data is the inverse of its address
`timescale 1ns/100ps
`default_nettype none
module tb;
    import icc_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, n0;
    logic fetch_req, iu_ready, iu_cti, irq_taken, flush_insn;
    logic fetch_valid, iu_hold, mem_ack, mem_err, err_inj, er;
    logic [31:0] fetch_addr, mem_rdata;
    logic [7:0] n_req;
    icc_fetch_type fetch_rsp, r;
    icc_mem_req_type mem_out;
    int fail_count, n_tests;
    icc_top icc_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .fetch_req(fetch_req),
        .fetch_addr(fetch_addr), .iu_ready(iu_ready), .iu_cti(iu_cti),
        .irq_taken(irq_taken), .flush_insn(flush_insn),
        .fetch_valid(fetch_valid), .fetch_rsp(fetch_rsp),
        .iu_hold(iu_hold), .mem_out(mem_out), .mem_ack(mem_ack),
        .mem_rdata(mem_rdata), .mem_err(mem_err));
    icc_mem_model icc_mem_model_inst (.pclk(pclk), .presetn(presetn),
        .mem_out(mem_out), .err_inj(err_inj), .mem_ack(mem_ack),
        .mem_rdata(mem_rdata), .mem_err(mem_err), .n_req(n_req));
    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: got %h expected %h", $time,
                got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] ad,
        input logic [31:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= ad;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic fetch(input logic [31:0] ad);
        @(posedge pclk);
        fetch_req <= 1'b1;
        fetch_addr <= ad;
        do @(posedge pclk); while (fetch_valid !== 1'b1);
        r = fetch_rsp;
        fetch_req <= 1'b0;
    endtask
    task automatic wait_flush;
        do apb(1'b0, 12'h000, 32'h0); while (rd[4] !== 1'b0);
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_reset;
        apb(1'b0, 12'h000, 32'h0);
        chk(rd, 32'h10);
        apb(1'b0, 12'h004, 32'h0);
        chk({31'h0, er}, 32'h1);
        fetch(32'h40000040);
        chk(r.data, ~32'h40000040);
        wait_flush;
    endtask
    task automatic t_enable;
        apb(1'b1, 12'h000, 32'h3);
        n0 = {24'h0, n_req};
        fetch(32'h40000100);
        chk(r.data, ~32'h40000100);
        fetch(32'h40000100);
        chk({24'h0, n_req}, n0 + 1);
        fetch(32'h20000000);
        fetch(32'h20000000);
        chk({24'h0, n_req}, n0 + 3);
        @(posedge pclk) flush_insn <= 1'b1;
        @(posedge pclk) flush_insn <= 1'b0;
        wait_flush;
        fetch(32'h40000100);
        chk({24'h0, n_req}, n0 + 4);
    endtask
    task automatic t_freeze;
        apb(1'b1, 12'h000, 32'h7);
        @(posedge pclk) irq_taken <= 1'b1;
        @(posedge pclk) irq_taken <= 1'b0;
        repeat (20) @(posedge pclk);
        apb(1'b0, 12'h000, 32'h0);
        chk({30'h0, rd[1:0]}, 32'h1);
        n0 = {24'h0, n_req};
        fetch(32'h40000200);
        fetch(32'h40000200);
        fetch(32'h40000100);
        chk({24'h0, n_req}, n0 + 2);
    endtask
    task automatic t_error;
        err_inj <= 1'b1;
        fetch(32'h40000300);
        chk({31'h0, r.err}, 32'h1);
        chk({24'h0, r.trap_type}, 32'h1);
        err_inj <= 1'b0;
        apb(1'b1, 12'h000, 32'h23);
        n0 = {24'h0, n_req};
        fetch(32'h40000418);
        fetch(32'h4000041c);
        chk(r.data, ~32'h4000041c);
        fetch(32'h4000041c);
        chk({24'h0, n_req}, n0 + 1);
    endtask
    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    initial begin
        repeat (30000) @(posedge pclk);
        fail_count++;
        stop_test;
    end
    initial begin
        {presetn, psel, penable, pwrite, fetch_req, iu_cti} = '0;
        {irq_taken, flush_insn, err_inj} = '0;
        iu_ready = 1'b1;
        paddr = 12'h0;
        pwdata = 32'h0;
        fetch_addr = 32'h0;
        fail_count = 0;
        n_tests = 0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        t_reset;
        t_enable;
        t_freeze;
        t_error;
        stop_test;
    end
endmodule
`default_nettype wire
